// [lps_pkg.sv]
package lps_pkg;

	// ----------------------------------------------------------------------
	// Geometry of the serial link
	// ----------------------------------------------------------------------
	localparam int LANES     = 4;
	localparam int SLICE     = 7;
	localparam int WORD_BITS = LANES * SLICE;
	localparam int IDX_W     = 5;

	// ----------------------------------------------------------------------
	// Forwarded clock shape and slot limits
	// ----------------------------------------------------------------------
	// Forwarded clock level per slot, slot 0 in the MSB: high, high, low x3, high, high.
	localparam logic [6:0] FWD_PATTERN = 7'h63;
	localparam logic [2:0] SLOT_FIRST  = 3'h0;
	localparam logic [2:0] SLOT_LAST   = 3'h6;
	localparam logic [2:0] SLOT_STEP   = 3'h1;

	// ----------------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------------
	localparam int CLK_PERIOD_PS   = 4000;
	localparam int PIX_MIN_MHZ     = 10;
	localparam int PIX_MAX_PERIOD  = 1000000 / PIX_MIN_MHZ;
	localparam int PIX_MAX_CYCLES  = PIX_MAX_PERIOD / CLK_PERIOD_PS;
	localparam int PERIOD_W_DEF    = 8;

	// ----------------------------------------------------------------------
	// Default lane and slot map: entry lane*7+slot names the input bit.
	// ----------------------------------------------------------------------
	typedef logic [WORD_BITS-1:0][IDX_W-1:0] lps_map_t;

	function automatic lps_map_t lps_default_map();
		lps_map_t m;
		for (int i = 0; i < WORD_BITS; i++) begin
			m[i] = IDX_W'(i);
		end
		return m;
	endfunction

	localparam lps_map_t DEFAULT_MAP = lps_default_map();

endpackage

// [lps_serializer.sv]
`timescale 1ns/1ps
`default_nettype none

module lps_serializer
	import lps_pkg::*;
#(
	parameter int       PERIOD_W = PERIOD_W_DEF, // Width of the pixel period counter.
	parameter lps_map_t LANE_MAP = DEFAULT_MAP   // Input bit index for each lane and slot.
) (
	input  wire logic                 clock,               // System clock, 250 MHz.
	input  wire logic                 rstn,                // Asynchronous reset, active low.
	input  wire logic                 pixel_clock_in,      // Pixel clock from the source.
	input  wire logic                 capture_edge_select, // High rising, low falling.
	input  wire logic                 power_down_n,        // Low shuts the block down.
	input  wire logic [WORD_BITS-1:0] parallel_pixel_bits, // Parallel pixel word.
	output logic      [LANES-1:0]     serial_lane_pair,    // Serial data per lane.
	output logic      [LANES-1:0]     serial_lane_oe,      // Driver enable per data lane.
	output logic                      forwarded_clock,     // Forwarded pixel clock.
	output logic                      forwarded_clock_oe   // Driver enable of clock lane.
);

	// ----------------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------------
	if (PERIOD_W < $clog2(PIX_MAX_CYCLES + 1)) begin : g_bad_width
		$error("PERIOD_W too small for the slowest pixel clock");
	end
	for (genvar i = 0; i < WORD_BITS; i++) begin : g_map_check
		if (LANE_MAP[i] >= WORD_BITS) begin : g_bad_map
			$error("LANE_MAP entry out of range");
		end
	end

	// ----------------------------------------------------------------------
	// State
	// ----------------------------------------------------------------------
	typedef struct packed {
		logic                             pixMeta;
		logic                             pixSync;
		logic                             pixPrev;
		logic                             selMeta;
		logic                             selSync;
		logic                             pdMeta;
		logic                             pdSync;
		logic [WORD_BITS-1:0]             datMeta;
		logic [WORD_BITS-1:0]             datSync;
		logic [WORD_BITS-1:0]             capWord;
		logic [LANES-1:0][SLICE-1:0]      shiftReg;
		logic [2:0]                       slot;
		logic [PERIOD_W-1:0]              acc;
		logic [PERIOD_W-1:0]              periodCnt;
		logic [PERIOD_W-1:0]              periodLen;
		logic [LANES-1:0]                 laneOut;
		logic                             fwdClk;
		logic                             drvEn;
	} lps_state_t;

	lps_state_t st_r;
	lps_state_t st_nxt;

	localparam logic [PERIOD_W-1:0] BIT_STEP = PERIOD_W'(SLICE);
	localparam logic [PERIOD_W-1:0] CNT_ONE  = PERIOD_W'(1);
	localparam logic [PERIOD_W-1:0] CNT_MAX  = '1;

	function automatic logic [LANES-1:0][SLICE-1:0] mapWord(input logic [WORD_BITS-1:0] w);
		logic [LANES-1:0][SLICE-1:0] s;
		s = '0;
		for (int l = 0; l < LANES; l++) begin
			for (int k = 0; k < SLICE; k++) begin
				s[l][SLICE-1-k] = w[LANE_MAP[l*SLICE+k]];
			end
		end
		return s;
	endfunction

	logic riseEdge;
	logic fallEdge;
	logic capEdge;
	logic bitTick;

	always_comb begin
		riseEdge = st_r.pixSync & ~st_r.pixPrev;
		fallEdge = ~st_r.pixSync & st_r.pixPrev;
		capEdge  = st_r.selSync ? riseEdge : fallEdge;
		// One spare bit keeps the sum from wrapping when the period nears the counter limit.
		bitTick  = (st_r.periodLen != '0)
			&& ({1'b0, st_r.acc} + {1'b0, BIT_STEP} >= {1'b0, st_r.periodLen});
	end

	// ----------------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------------
	always_comb begin
		st_nxt         = st_r;
		st_nxt.pixMeta = pixel_clock_in;
		st_nxt.pixSync = st_r.pixMeta;
		st_nxt.pixPrev = st_r.pixSync;
		st_nxt.selMeta = capture_edge_select;
		st_nxt.selSync = st_r.selMeta;
		st_nxt.pdMeta  = power_down_n;
		st_nxt.pdSync  = st_r.pdMeta;
		st_nxt.datMeta = parallel_pixel_bits;
		st_nxt.datSync = st_r.datMeta;
		if (!st_r.pdSync) begin
			// Shutdown clears everything past the synchronisers and stops the bit timing.
			st_nxt.capWord   = '0;
			st_nxt.shiftReg  = '0;
			st_nxt.slot      = SLOT_FIRST;
			st_nxt.acc       = '0;
			st_nxt.periodCnt = '0;
			st_nxt.periodLen = '0;
		end else begin
			st_nxt.periodCnt = (st_r.periodCnt == CNT_MAX) ? CNT_MAX : st_r.periodCnt + CNT_ONE;
			if (capEdge) begin
				st_nxt.capWord   = st_r.datSync;
				st_nxt.shiftReg  = mapWord(st_r.datSync);
				st_nxt.slot      = SLOT_FIRST;
				st_nxt.acc       = '0;
				st_nxt.periodCnt = CNT_ONE;
				st_nxt.periodLen = st_r.periodCnt;
			end else if (bitTick) begin
				// The fractional step keeps seven slots inside one measured pixel period.
				st_nxt.acc = st_r.acc + BIT_STEP - st_r.periodLen;
				if (st_r.slot != SLOT_LAST) begin
					st_nxt.slot = st_r.slot + SLOT_STEP;
					for (int l = 0; l < LANES; l++) begin
						st_nxt.shiftReg[l] = {st_r.shiftReg[l][SLICE-2:0], 1'b0};
					end
				end
			end else begin
				st_nxt.acc = st_r.acc + BIT_STEP;
			end
		end
		for (int l = 0; l < LANES; l++) begin
			st_nxt.laneOut[l] = st_nxt.shiftReg[l][SLICE-1] & st_r.pdSync;
		end
		st_nxt.fwdClk = FWD_PATTERN[3'(SLOT_LAST - st_nxt.slot)] & st_r.pdSync;
		st_nxt.drvEn  = st_r.pdSync;
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign serial_lane_pair   = st_r.laneOut;
	assign serial_lane_oe     = {LANES{st_r.drvEn}};
	assign forwarded_clock    = st_r.fwdClk;
	assign forwarded_clock_oe = st_r.drvEn;

	// ----------------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------------
	chk_pd_drivers_off: assert property (@(posedge clock) disable iff (!rstn)
		!st_r.pdSync |=> (serial_lane_oe == '0) && !forwarded_clock_oe)
		else $error("drivers enabled during power-down");

	chk_pd_regs_clear: assert property (@(posedge clock) disable iff (!rstn)
		!st_r.pdSync |=> (st_r.capWord == '0) && (st_r.shiftReg == '0) && (st_r.slot == '0))
		else $error("registers not cleared during power-down");

	chk_pd_outputs_low: assert property (@(posedge clock) disable iff (!rstn)
		!st_r.pdSync ##1 !st_r.pdSync |=> (serial_lane_pair == '0) && !forwarded_clock)
		else $error("outputs toggle during power-down");

	chk_capture_word: assert property (@(posedge clock) disable iff (!rstn)
		st_r.pdSync && capEdge |=> st_r.capWord == $past(st_r.datSync))
		else $error("pixel word not captured on edge");

	chk_edge_select: assert property (@(posedge clock) disable iff (!rstn)
		st_r.pdSync && (st_r.pixSync != st_r.pixPrev) && (st_r.pixSync == st_r.selSync)
		|=> st_r.slot == SLOT_FIRST && st_r.periodCnt == CNT_ONE)
		else $error("wrong capture edge used");

	chk_slice_load: assert property (@(posedge clock) disable iff (!rstn)
		st_r.pdSync && capEdge |=> st_r.shiftReg == mapWord(st_r.capWord))
		else $error("slices differ from captured word");

	chk_lane_shift: assert property (@(posedge clock) disable iff (!rstn)
		st_r.pdSync && !capEdge && bitTick && st_r.slot != SLOT_LAST
		|=> st_r.slot == $past(st_r.slot) + SLOT_STEP
		&& st_r.shiftReg[0] == {$past(st_r.shiftReg[0][SLICE-2:0]), 1'b0})
		else $error("lane did not shift on bit tick");

	chk_slot_bound: assert property (@(posedge clock) disable iff (!rstn)
		st_r.slot <= SLOT_LAST)
		else $error("slot beyond slice length");

	chk_fwd_clock_shape: assert property (@(posedge clock) disable iff (!rstn)
		st_r.pdSync && st_r.drvEn ##1 st_r.pdSync
		|-> forwarded_clock == FWD_PATTERN[3'(SLOT_LAST - st_r.slot)])
		else $error("forwarded clock off its slot pattern");

	chk_drivers_on: assert property (@(posedge clock) disable iff (!rstn)
		st_r.pdSync |=> (serial_lane_oe == '1) && forwarded_clock_oe)
		else $error("line drivers off while running");

	chk_lane_msb_out: assert property (@(posedge clock) disable iff (!rstn)
		st_r.pdSync |=> serial_lane_pair[0] == st_r.shiftReg[0][SLICE-1])
		else $error("lane output differs from shift register head");

	// Once a period lasts at least two clock cycles per slot, two bit steps can never fall on adjacent cycles.
	chk_tick_spacing: assert property (@(posedge clock) disable iff (!rstn)
		st_r.pdSync && !capEdge && bitTick && (st_r.periodLen >= PERIOD_W'(2 * SLICE))
		|=> !bitTick)
		else $error("bit ticks closer than one slot");

endmodule // lps_serializer

`default_nettype wire

// [lps_src_model.sv]
`timescale 1ns/1ps
`default_nettype none

module lps_src_model
	import lps_pkg::*;
(
	input  wire logic                 capture_edge_select, // Edge the block captures on.
	input  wire logic [WORD_BITS-1:0] nextWord,            // Word to launch next.
	output logic                      pixel_clock_in,      // Free running pixel clock.
	output logic      [WORD_BITS-1:0] parallel_pixel_bits  // Word held around capture.
);
	// Launching on the opposite edge keeps the word settled half a period around capture.
	initial begin
		pixel_clock_in = 1'b0;
		parallel_pixel_bits = '0;
		// A quarter nanosecond offset keeps every pixel edge off the system clock edges.
		#0.25;
		forever begin
			#62.5; // Half period of the bench pixel clock.
			pixel_clock_in = ~pixel_clock_in;
			if (pixel_clock_in != capture_edge_select) begin
				parallel_pixel_bits = nextWord;
			end
		end
	end
endmodule // lps_src_model

`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import lps_pkg::*;
	logic                 clock = 1'b0;
	logic                 rstn = 1'b0;
	logic                 capSel = 1'b1;
	logic                 pdN = 1'b1;
	logic [WORD_BITS-1:0] word = '0;
	logic                 pixClk;
	logic [WORD_BITS-1:0] pixBits;
	logic [LANES-1:0]     lanes;
	logic [LANES-1:0]     lanesOe;
	logic                 fwdClk;
	logic                 fwdOe;
	int                   n_fail = 0;
	int                   cmp_count = 0;

	always #2 clock = ~clock;

	lps_src_model i_src (.capture_edge_select(capSel), .nextWord(word),
		.pixel_clock_in(pixClk), .parallel_pixel_bits(pixBits));

	lps_serializer i_dut (.clock(clock), .rstn(rstn), .pixel_clock_in(pixClk),
		.capture_edge_select(capSel), .power_down_n(pdN), .parallel_pixel_bits(pixBits),
		.serial_lane_pair(lanes), .serial_lane_oe(lanesOe), .forwarded_clock(fwdClk),
		.forwarded_clock_oe(fwdOe));

	// ----------------------------------------------------------------------
	// Shared checks
	// ----------------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Samples each slot near its centre; slot 0 starts about ten nanoseconds after the pin edge.
	task automatic send_word(input logic [WORD_BITS-1:0] w);
		logic [WORD_BITS-1:0] got;
		logic [SLICE-1:0]     fwd;
		word = w;
		if (capSel) begin
			@(negedge pixClk);
			@(posedge pixClk);
		end else begin
			@(posedge pixClk);
			@(negedge pixClk);
		end
		#18.93;
		for (int k = 0; k < SLICE; k++) begin
			for (int l = 0; l < LANES; l++) begin
				got[l*SLICE+k] = lanes[l];
			end
			fwd[SLICE-1-k] = fwdClk;
			#17.857;
		end
		chk(32'(got), 32'(w));
		chk(32'(fwd), 32'(FWD_PATTERN));
		chk(32'({lanesOe, fwdOe}), 32'h0000_001F);
	endtask

	// ----------------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------------
	task automatic test_rising();
		logic [WORD_BITS-1:0] words [4];
		words = '{28'h000_0001, 28'h800_0000, 28'hFFF_FFFF, 28'h5A3_C96E};
		foreach (words[i]) begin
			send_word(words[i]);
		end
		send_word(28'h77C_F3DF);
	endtask

	task automatic test_falling();
		@(posedge clock);
		#1 capSel = 1'b0;
		repeat (3) @(posedge pixClk);
		send_word(28'h0F0_F0F0);
		send_word(28'h123_4567);
	endtask

	task automatic test_shutdown();
		@(posedge pixClk);
		#30;
		@(posedge clock);
		#1 pdN = 1'b0;
		repeat (4) @(posedge clock);
		#1;
		chk(32'({lanes, lanesOe, fwdClk, fwdOe}), 32'h0000_0000);
		repeat (3) @(posedge pixClk);
		#1;
		chk(32'({lanes, lanesOe, fwdClk, fwdOe}), 32'h0000_0000);
		@(posedge clock);
		#1 pdN = 1'b1;
		repeat (4) @(posedge clock);
		#1;
		chk(32'({lanes, lanesOe, fwdClk, fwdOe}), 32'h0000_003F);
		repeat (3) @(posedge pixClk);
		send_word(28'hC3C_3C3C);
	endtask

	initial begin
		repeat (5) @(posedge clock);
		#1 rstn = 1'b1;
		// The first pixel period after start is only measured, so let it pass.
		repeat (3) @(posedge pixClk);
		test_rising();
		test_falling();
		test_shutdown();
		summarize();
	end

	initial begin
		#20us;
		n_fail++;
		summarize();
	end
endmodule // tb_top

`default_nettype wire
